// ### button_pkg.sv
// Constants, register map and helper functions for the button decision block.
package button_pkg;
  localparam logic [7:0] ADDR_BUTTON_CONFIG = 8'h21;
  localparam logic [7:0] ADDR_AVG_SUSPEND = 8'h22;
  localparam logic [7:0] ADDR_NEG_LEVEL = 8'h23;
  localparam logic [7:0] ADDR_NEG_LIMIT = 8'h24;
  localparam logic [7:0] ADDR_HYSTERESIS = 8'h25;
  localparam logic [7:0] ADDR_STUCK_TIMEOUT = 8'h26;
  localparam logic [7:0] ADDR_STATE_LOW = 8'h40;
  localparam logic [7:0] ADDR_STATE_HIGH = 8'h41;

  localparam logic [7:0] RESET_BUTTON_CONFIG = 8'h30;
  localparam logic [7:0] RESET_AVG_SUSPEND = 8'h50;
  localparam logic [7:0] RESET_NEG_LEVEL = 8'h50;
  localparam logic [7:0] RESET_NEG_LIMIT = 8'h01;
  localparam logic [7:0] RESET_HYSTERESIS = 8'h0a;
  localparam logic [7:0] RESET_STUCK_TIMEOUT = 8'h00;

  localparam int REPORT_MODE_MSB = 7;
  localparam int REPORT_MODE_LSB = 6;
  localparam int IRQ_SEL_MSB = 5;
  localparam int IRQ_SEL_LSB = 4;
  localparam int REL_DEB_MSB = 3;
  localparam int REL_DEB_LSB = 2;
  localparam int TOUCH_DEB_MSB = 1;
  localparam int TOUCH_DEB_LSB = 0;

  localparam logic [6:0] HYST_FULL = 7'h64;
  localparam int LEVEL_SHIFT = 2;
  localparam int MULTI_SUSPEND_COUNT = 3;

  localparam int SECOND_MS = 1000;
  localparam int CLK_MHZ = 200;
  localparam int SECOND_CYCLES = SECOND_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    REPORT_MULTI = 2'b00,
    REPORT_SINGLE = 2'b01,
    REPORT_RSVD_A = 2'b10,
    REPORT_RSVD_B = 2'b11
  } report_mode_t;

  typedef enum logic [1:0] {
    IRQ_MASKED = 2'b00,
    IRQ_TOUCH = 2'b01,
    IRQ_RELEASE = 2'b10,
    IRQ_BOTH = 2'b11
  } irq_sel_t;

  // Samples needed to confirm a decision; code 00 means the current sample decides.
  function automatic logic [2:0] debounce_need(input logic [1:0] code);
    debounce_need = {1'b0, code} + 3'h1;
  endfunction

  // Register value times four, as used by the suspend and negative levels.
  function automatic logic signed [31:0] level_x4(input logic [7:0] value);
    level_x4 = $signed({22'h0, value, 2'b00});
  endfunction
endpackage

// ### button_cfg_if.sv
// Shared configuration and timing strobes passed from the control block to each button.
`timescale 1ns/1ps
interface button_cfg_if;
  logic scan_en;
  logic sec_en;
  logic comp_clear;
  logic [1:0] touch_deb;
  logic [1:0] rel_deb;
  logic [6:0] hyst_pct;
  logic [7:0] stuck_limit;
  logic [7:0] neg_limit;
  logic [7:0] avg_level;
  logic [7:0] neg_level;

  modport ctrl (
    output scan_en, sec_en, comp_clear, touch_deb, rel_deb, hyst_pct,
    output stuck_limit, neg_limit, avg_level, neg_level
  );
  modport btn (
    input scan_en, sec_en, comp_clear, touch_deb, rel_deb, hyst_pct,
    input stuck_limit, neg_limit, avg_level, neg_level
  );
endinterface

// ### second_pulse.sv
// Divider that produces a one-cycle pulse once per second of the system clock.
`timescale 1ns/1ps
module second_pulse #(
  parameter int CYCLES = button_pkg::SECOND_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  import button_pkg::*;

  logic [31:0] count;
  wire last = (count == 32'(CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else begin
      count <= last ? 32'h0 : count + 32'h1;
      tick <= last;
    end
  end
endmodule

// ### button_decision.sv
// Touch and release decision for one sensor, with debounce, stuck timer and negative count.
`timescale 1ns/1ps
module button_decision #(
  parameter int TICK_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  button_cfg_if.btn cfg,
  input wire logic signed [TICK_W-1:0] tick,
  input wire logic [7:0] sensor_touch_level,
  output logic touched,
  output logic touch_evt,
  output logic release_evt,
  output logic avg_hold,
  output logic neg_req,
  output logic stuck_req
);
  import button_pkg::*;

  logic [2:0] deb_cnt;
  logic [7:0] neg_cnt;
  logic [7:0] stuck_secs;
  logic stuck_hold;

  // Ticks are scaled by 100 so the percentage hysteresis needs no divider.
  wire logic signed [31:0] tick_x = 32'(tick) * 32'sd100;
  wire logic signed [31:0] lvl = $signed({24'h0, sensor_touch_level});
  wire logic signed [31:0] pct = $signed({25'h0, cfg.hyst_pct});
  wire logic signed [31:0] full = $signed({25'h0, HYST_FULL});
  wire above = tick_x > lvl * (full + pct);
  wire below = tick_x < lvl * (full - pct);
  wire [2:0] need = touched ? debounce_need(cfg.rel_deb) : debounce_need(cfg.touch_deb);
  wire [2:0] deb_next = deb_cnt + 3'h1;
  wire candidate = touched ? below : (above && !stuck_hold);
  wire neg_hit = 32'(tick) < -level_x4(cfg.neg_level);
  // A scan that meets a compensation clear in the same cycle still counts its sample.
  wire [7:0] neg_base = cfg.comp_clear ? 8'h0 : neg_cnt;
  wire [7:0] neg_next = (neg_base == 8'hff) ? neg_base : neg_base + 8'h1;
  wire stuck_fire = touched && cfg.sec_en && (cfg.stuck_limit != 8'h00)
                    && (stuck_secs + 8'h1 >= cfg.stuck_limit);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      touched <= 1'b0;
      touch_evt <= 1'b0;
      release_evt <= 1'b0;
      deb_cnt <= 3'h0;
      stuck_hold <= 1'b0;
    end else begin
      touch_evt <= 1'b0;
      release_evt <= 1'b0;
      if (stuck_fire) begin
        // A finger held past the timeout is reported released; a new touch waits
        // until a scan finds the sensor no longer above level plus level times hysteresis.
        touched <= 1'b0;
        release_evt <= 1'b1;
        stuck_hold <= 1'b1;
        deb_cnt <= 3'h0;
      end else if (cfg.scan_en) begin
        if (!above) begin
          stuck_hold <= 1'b0;
        end
        if (candidate) begin
          if (deb_next >= need) begin
            touched <= !touched;
            touch_evt <= !touched;
            release_evt <= touched;
            deb_cnt <= 3'h0;
          end else begin
            deb_cnt <= deb_next;
          end
        end else begin
          deb_cnt <= 3'h0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stuck_secs <= 8'h0;
      stuck_req <= 1'b0;
    end else begin
      stuck_req <= stuck_fire;
      if (!touched || stuck_fire) begin
        stuck_secs <= 8'h0;
      end else if (cfg.sec_en && stuck_secs != 8'hff) begin
        stuck_secs <= stuck_secs + 8'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avg_hold <= 1'b0;
      neg_cnt <= 8'h0;
      neg_req <= 1'b0;
    end else begin
      neg_req <= 1'b0;
      if (cfg.scan_en) begin
        avg_hold <= 32'(tick) > level_x4(cfg.avg_level);
        if (!neg_hit) begin
          neg_cnt <= 8'h0;
        end else if (neg_next >= cfg.neg_limit) begin
          neg_req <= 1'b1;
          neg_cnt <= 8'h0;
        end else begin
          neg_cnt <= neg_next;
        end
      end else if (cfg.comp_clear) begin
        neg_cnt <= 8'h0;
      end
    end
  end
endmodule

// ### button_touch_decision.sv
// Button touch and release decision with register file, reporting and compensation triggers.
//
// Contract
// - Mode 00 reports all; 01 first touch only.
// - Bits 5:4 choose touch, release or both events.
// - Bits 3:2 set release debounce samples.
// - Bits 1:0 set touch debounce samples.
// - Debounce counts once per scan period.
// - Touch above level plus level times hysteresis.
// - Release below level minus level times hysteresis.
// - Hysteresis percent 0 to 100, reset ten.
// - Averaging suspended while ticks exceed level times four.
// - Three suspended sensors trigger offset compensation.
// - Negative level is register times four.
// - Negative sample count reaching limit triggers compensation.
// - Stuck timeout zero off, else seconds.
// - Proximity sensors use identical button processing.
// - Stuck touch compensates and reports a release.
`timescale 1ns/1ps
module button_touch_decision #(
  parameter int NUM_BUTTONS = 12,
  parameter int TICK_W = 16,
  parameter int SECOND_CYCLES = button_pkg::SECOND_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic scan_en,
  input wire logic [NUM_BUTTONS*TICK_W-1:0] sense_input,
  input wire logic [NUM_BUTTONS*8-1:0] sensor_touch_level,
  output logic [NUM_BUTTONS-1:0] button_state,
  output logic [NUM_BUTTONS-1:0] touch_report,
  output logic [NUM_BUTTONS-1:0] release_report,
  output logic event_alert,
  output logic [NUM_BUTTONS-1:0] avg_suspend,
  output logic comp_request
);
  import button_pkg::*;

  logic [7:0] button_config;
  logic [7:0] average_suspend_level;
  logic [7:0] negative_comp_level;
  logic [7:0] negative_count_limit;
  logic [7:0] touch_hysteresis_pct;
  logic [7:0] stuck_touch_timeout;
  logic [NUM_BUTTONS-1:0] owner;
  logic sec_tick;

  logic [NUM_BUTTONS-1:0] btn_touched;
  logic [NUM_BUTTONS-1:0] btn_touch_evt;
  logic [NUM_BUTTONS-1:0] btn_release_evt;
  logic [NUM_BUTTONS-1:0] btn_avg_hold;
  logic [NUM_BUTTONS-1:0] btn_neg_req;
  logic [NUM_BUTTONS-1:0] btn_stuck_req;

  button_cfg_if cfg_bus ();

  second_pulse #(
    .CYCLES(SECOND_CYCLES)
  ) u_second (
    .clk(clk),
    .rst_n(rst_n),
    .tick(sec_tick)
  );

  // Out-of-range hysteresis is clamped so the release level never goes negative.
  wire [6:0] hyst_clamped = (touch_hysteresis_pct > {1'b0, HYST_FULL}) ? HYST_FULL
                            : touch_hysteresis_pct[6:0];
  wire [7:0] neg_limit_eff = (negative_count_limit == 8'h00) ? 8'h01 : negative_count_limit;

  assign cfg_bus.scan_en = scan_en;
  assign cfg_bus.sec_en = sec_tick;
  assign cfg_bus.comp_clear = comp_request;
  assign cfg_bus.touch_deb = button_config[TOUCH_DEB_MSB:TOUCH_DEB_LSB];
  assign cfg_bus.rel_deb = button_config[REL_DEB_MSB:REL_DEB_LSB];
  assign cfg_bus.hyst_pct = hyst_clamped;
  assign cfg_bus.stuck_limit = stuck_touch_timeout;
  assign cfg_bus.neg_limit = neg_limit_eff;
  assign cfg_bus.avg_level = average_suspend_level;
  assign cfg_bus.neg_level = negative_comp_level;

  // Proximity sensors are simply further instances of the same decision logic.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BUTTONS; gi = gi + 1) begin : g_btn
      button_decision #(
        .TICK_W(TICK_W)
      ) u_btn (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg_bus.btn),
        .tick(sense_input[gi*TICK_W +: TICK_W]),
        .sensor_touch_level(sensor_touch_level[gi*8 +: 8]),
        .touched(btn_touched[gi]),
        .touch_evt(btn_touch_evt[gi]),
        .release_evt(btn_release_evt[gi]),
        .avg_hold(btn_avg_hold[gi]),
        .neg_req(btn_neg_req[gi]),
        .stuck_req(btn_stuck_req[gi])
      );
    end
  endgenerate

  function automatic logic [7:0] count_ones(input logic [NUM_BUTTONS-1:0] v);
    logic [7:0] n;
    n = 8'h0;
    for (int i = 0; i < NUM_BUTTONS; i++) begin
      n = n + {7'h0, v[i]};
    end
    count_ones = n;
  endfunction

  // Lowest-index touch wins when several arrive in one scan in single mode.
  function automatic logic [NUM_BUTTONS-1:0] lowest_bit(input logic [NUM_BUTTONS-1:0] v);
    lowest_bit = v & (~v + {{(NUM_BUTTONS-1){1'b0}}, 1'b1});
  endfunction

  wire report_mode_t mode = report_mode_t'(button_config[REPORT_MODE_MSB:REPORT_MODE_LSB]);
  wire single = (mode == REPORT_SINGLE);
  wire irq_sel_t irq_sel = irq_sel_t'(button_config[IRQ_SEL_MSB:IRQ_SEL_LSB]);
  wire owner_free = (owner == '0);
  wire [NUM_BUTTONS-1:0] first_touch = lowest_bit(btn_touch_evt);
  wire [NUM_BUTTONS-1:0] rep_touch = !single ? btn_touch_evt
                                    : (owner_free ? first_touch : '0);
  wire [NUM_BUTTONS-1:0] rep_release = !single ? btn_release_evt
                                      : (btn_release_evt & owner);
  wire [NUM_BUTTONS-1:0] next_owner = !single ? '0
                                     : (owner_free ? first_touch : (owner & ~btn_release_evt));
  wire want_touch_irq = (irq_sel == IRQ_TOUCH) || (irq_sel == IRQ_BOTH);
  wire want_release_irq = (irq_sel == IRQ_RELEASE) || (irq_sel == IRQ_BOTH);
  wire next_alert = (want_touch_irq && (rep_touch != '0))
                    || (want_release_irq && (rep_release != '0));
  wire multi_suspend = scan_en
                       && (count_ones(btn_avg_hold) >= 8'(MULTI_SUSPEND_COUNT));
  wire next_comp = multi_suspend || (btn_neg_req != '0) || (btn_stuck_req != '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      owner <= '0;
      button_state <= '0;
      touch_report <= '0;
      release_report <= '0;
      event_alert <= 1'b0;
      avg_suspend <= '0;
      comp_request <= 1'b0;
    end else begin
      owner <= next_owner;
      button_state <= (button_state | rep_touch) & ~rep_release;
      touch_report <= rep_touch;
      release_report <= rep_release;
      event_alert <= next_alert;
      avg_suspend <= btn_avg_hold;
      comp_request <= next_comp;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      button_config <= RESET_BUTTON_CONFIG;
      average_suspend_level <= RESET_AVG_SUSPEND;
      negative_comp_level <= RESET_NEG_LEVEL;
      negative_count_limit <= RESET_NEG_LIMIT;
      touch_hysteresis_pct <= RESET_HYSTERESIS;
      stuck_touch_timeout <= RESET_STUCK_TIMEOUT;
    end else if (reg_write) begin
      case (reg_addr)
        ADDR_BUTTON_CONFIG: begin
          button_config <= reg_wdata;
        end
        ADDR_AVG_SUSPEND: begin
          average_suspend_level <= reg_wdata;
        end
        ADDR_NEG_LEVEL: begin
          negative_comp_level <= reg_wdata;
        end
        ADDR_NEG_LIMIT: begin
          negative_count_limit <= reg_wdata;
        end
        ADDR_HYSTERESIS: begin
          touch_hysteresis_pct <= reg_wdata;
        end
        ADDR_STUCK_TIMEOUT: begin
          stuck_touch_timeout <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  logic [15:0] state_wide;
  assign state_wide = 16'(button_state);

  logic [7:0] read_value;
  always_comb begin
    case (reg_addr)
      ADDR_BUTTON_CONFIG: read_value = button_config;
      ADDR_AVG_SUSPEND: read_value = average_suspend_level;
      ADDR_NEG_LEVEL: read_value = negative_comp_level;
      ADDR_NEG_LIMIT: read_value = negative_count_limit;
      ADDR_HYSTERESIS: read_value = touch_hysteresis_pct;
      ADDR_STUCK_TIMEOUT: read_value = stuck_touch_timeout;
      ADDR_STATE_LOW: read_value = state_wide[7:0];
      ADDR_STATE_HIGH: read_value = state_wide[15:8];
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= read_value;
    end
  end
endmodule

// ### button_touch_decision_sva.sv
// Port-level assertions and covers for the button decision block.
`timescale 1ns/1ps
module button_touch_decision_sva #(
  parameter int NUM_BUTTONS = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic scan_en,
  input wire logic [NUM_BUTTONS-1:0] button_state,
  input wire logic [NUM_BUTTONS-1:0] touch_report,
  input wire logic [NUM_BUTTONS-1:0] release_report,
  input wire logic event_alert,
  input wire logic [NUM_BUTTONS-1:0] avg_suspend,
  input wire logic comp_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_touch_sets_state: assert property ((touch_report & ~button_state) == '0)
    else $error("touch report without touched state");
  a_release_clears_state: assert property ((release_report & button_state) == '0)
    else $error("release report while still touched");
  a_rise_is_touch: assert property ((button_state & ~$past(button_state)) == touch_report)
    else $error("state rise and touch report differ");
  a_fall_is_release: assert property ((~button_state & $past(button_state)) == release_report)
    else $error("state fall and release report differ");
  a_alert_has_event: assert property (event_alert |-> (touch_report | release_report) != '0)
    else $error("alert without a reported event");
  a_suspend_at_scan: assert property (!$stable(avg_suspend) |-> $past(scan_en, 2))
    else $error("suspend flags moved away from a scan");
  a_touch_after_scan: assert property (touch_report != '0 |-> $past(scan_en, 2))
    else $error("touch report not two cycles after a scan");
  a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  c_touch: cover property (touch_report != '0);
  c_release: cover property (release_report != '0);
  c_comp: cover property (comp_request);
endmodule

bind button_touch_decision button_touch_decision_sva #(.NUM_BUTTONS(NUM_BUTTONS)) sva_inst (
  .clk(clk), .rst_n(rst_n), .reg_read(reg_read), .reg_rdata(reg_rdata), .scan_en(scan_en),
  .button_state(button_state), .touch_report(touch_report), .release_report(release_report),
  .event_alert(event_alert), .avg_suspend(avg_suspend), .comp_request(comp_request)
);

// ### button_host.sv
// Host model that writes and reads the parameter registers.
`timescale 1ns/1ps
module button_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_wdata,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
  end
  // Idle lines show inverted values so a stale address or datum is never read as live.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// ### button_touch_decision_tb_top.sv
// Self-checking bench for the button decision block.
`timescale 1ns/1ps
module button_touch_decision_tb_top;
  import button_pkg::*;
  localparam int NB = 12;
  logic clk, rst_n, reg_write, reg_read, scan_en, event_alert, comp_request, alert, comp;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, avg, d;
  logic [NB*16-1:0] sense_input;
  logic [NB*8-1:0] sensor_touch_level;
  logic [NB-1:0] button_state, touch_report, release_report, avg_suspend;
  logic [NB-1:0] st, tr, rr, ex_tr, ex_rr, sus;
  logic [1:0] tdeb, rdeb, irq;
  logic [6:0] pct;
  logic [7:0] rst_tab [6] = '{8'h30, 8'h50, 8'h50, 8'h01, 8'h0a, 8'h00};
  int cnt [NB];
  int miscompares, checks, n;

  button_touch_decision #(.NUM_BUTTONS(NB), .TICK_W(16), .SECOND_CYCLES(20))
    button_touch_decision_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .scan_en(scan_en), .sense_input(sense_input), .sensor_touch_level(sensor_touch_level),
    .button_state(button_state), .touch_report(touch_report), .release_report(release_report),
    .event_alert(event_alert), .avg_suspend(avg_suspend), .comp_request(comp_request));
  button_host button_host_inst (.clk(clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reference decision: a counter of consecutive qualifying scans per button.
  function automatic void predict();
    int t, l, need, p, a;
    logic q;
    ex_tr = '0;
    ex_rr = '0;
    // Signed copies keep negative ticks from being compared as huge unsigned values.
    p = pct;
    a = avg;
    for (int i = 0; i < NB; i++) begin
      t = $signed(sense_input[i*16 +: 16]);
      l = sensor_touch_level[i*8 +: 8];
      sus[i] = t > a * 4;
      q = st[i] ? (t * 100 < l * (100 - p)) : (t * 100 > l * (100 + p));
      need = st[i] ? rdeb + 1 : tdeb + 1;
      cnt[i] = q ? cnt[i] + 1 : 0;
      if (cnt[i] >= need) begin
        cnt[i] = 0;
        st[i] = ~st[i];
        ex_tr[i] = st[i];
        ex_rr[i] = ~st[i];
      end
    end
  endfunction

  task automatic scan;
    @(negedge clk);
    scan_en = 1'b1;
    @(negedge clk);
    scan_en = 1'b0;
    // The multi-sensor request stands from the scan edge itself, reports and per-button requests one cycle later.
    comp = comp_request;
    @(negedge clk);
    comp = comp | comp_request;
    tr = touch_report;
    rr = release_report;
    alert = event_alert;
    @(negedge clk);
  endtask

  task automatic scan_chk;
    predict();
    scan();
    check(button_state, st);
    check(tr, ex_tr);
    check(rr, ex_rr);
    check(alert, (irq[0] & |ex_tr) | (irq[1] & |ex_rr));
    check(avg_suspend, sus);
  endtask

  task automatic cfg(input logic [1:0] mode);
    button_host_inst.wr(ADDR_BUTTON_CONFIG, {mode, irq, rdeb, tdeb});
  endtask

  task automatic tick0(input logic [15:0] v);
    sense_input[15:0] = v;
    scan_chk();
  endtask

  initial begin
    void'($urandom(9));
    rst_n = 1'b0;
    scan_en = 1'b0;
    sense_input = '0;
    sensor_touch_level = {NB{8'd100}};
    st = '0;
    cnt = '{default: 0};
    {tdeb, rdeb, pct, avg, irq} = {2'b00, 2'b00, 7'd10, 8'h50, 2'b11};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      button_host_inst.rd(8'h21 + 8'(i), d);
      check(d, rst_tab[i]);
    end
    button_host_inst.rd(8'h30, d);
    check(d, 8'h00);
    button_host_inst.wr(8'h40, 8'hff);
    button_host_inst.rd(8'h40, d);
    check(d, 8'h00);
    foreach (rst_tab[k]) begin
      if (k < 4) begin
        tick0(k[0] ? 16'd111 - 16'(k / 2 * 22) : 16'd110 - 16'(k / 2 * 20));
      end
    end
    for (int m = 0; m < 4; m++) begin
      irq = 2'(m);
      cfg(2'b00);
      tick0(16'd500);
      tick0(16'd0);
    end
    for (int m = 0; m < 4; m++) begin
      if (m != 1) begin
        cfg(2'(m));
        tick0(16'd500);
        sense_input[31:16] = 16'd500;
        scan_chk();
        sense_input[31:0] = '0;
        scan_chk();
      end
    end
    cfg(2'b01);
    sense_input[15:0] = 16'd500;
    scan();
    check(tr, 12'h001);
    sense_input[31:16] = 16'd500;
    scan();
    check(tr, 12'h000);
    sense_input[31:16] = '0;
    scan();
    check(rr, 12'h000);
    sense_input[15:0] = '0;
    scan();
    check(rr, 12'h001);
    cfg(2'b00);
    button_host_inst.wr(ADDR_NEG_LIMIT, 8'h01);
    tick0(-16'sd321);
    check(comp, 1'b1);
    tick0(-16'sd320);
    check(comp, 1'b0);
    button_host_inst.wr(ADDR_NEG_LIMIT, 8'h03);
    for (int k = 1; k <= 3; k++) begin
      tick0(-16'sd400);
      check(comp, k == 3);
    end
    sense_input[47:0] = {16'd320, 16'd321, 16'd321};
    scan_chk();
    scan_chk();
    check(comp, 1'b0);
    sense_input[47:32] = 16'd321;
    scan_chk();
    scan_chk();
    check(comp, 1'b1);
    sense_input = '0;
    scan_chk();
    scan_chk();
    button_host_inst.wr(ADDR_STUCK_TIMEOUT, 8'h02);
    tick0(16'd500);
    n = 0;
    comp = 1'b0;
    while (release_report[0] !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
      comp = comp | comp_request;
    end
    comp = comp | comp_request;
    check(n >= 15 && n <= 45, 1'b1);
    check(comp, 1'b1);
    st[0] = 1'b0;
    tick0(16'd0);
    button_host_inst.wr(ADDR_STUCK_TIMEOUT, 8'h00);
    tick0(16'd500);
    rr = '0;
    repeat (60) begin
      @(negedge clk);
      rr = rr | release_report;
    end
    check(rr, 12'h000);
    button_host_inst.rd(ADDR_STATE_LOW, d);
    check(d, 8'h01);
    button_host_inst.rd(ADDR_STATE_HIGH, d);
    check(d, 8'h00);
    tick0(16'd0);
    for (int b = 0; b < 20; b++) begin
      {tdeb, rdeb, avg} = 12'($urandom);
      pct = 7'($urandom_range(100));
      cfg(2'b00);
      button_host_inst.wr(ADDR_HYSTERESIS, {1'b0, pct});
      button_host_inst.wr(ADDR_AVG_SUSPEND, avg);
      for (int i = 0; i < NB; i++) begin
        sensor_touch_level[i*8 +: 8] = 8'($urandom_range(200, 20));
      end
      repeat (8) begin
        for (int i = 0; i < NB; i++) begin
          sense_input[i*16 +: 16] = 16'($urandom_range(600));
        end
        scan_chk();
      end
    end
    tally_and_finish();
  end
endmodule
